/* File: verilog/mec_pkg.sv */
package mec_pkg;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int          MEC_CNT_W     = 16;
  localparam logic [15:0] MEC_CNT_RST   = 16'h0000;
  localparam logic [15:0] MEC_CNT_STEP  = 16'h0001;
  localparam int          MEC_ENTRIES   = 2;

  // ------------------------------------------------------------------
  // source selections
  // ------------------------------------------------------------------
  typedef enum logic {
    MEC_CLK_PIN  = 1'b0,
    MEC_CLK_CAP1 = 1'b1
  } mec_clk_sel_t;

  typedef enum logic [1:0] {
    MEC_RST_NONE  = 2'h0,
    MEC_RST_PIN   = 2'h1,
    MEC_RST_CAP0  = 2'h2,
    MEC_RST_MATCH = 2'h3
  } mec_rst_sel_t;

  // one entry of the event match store
  typedef struct packed {
    logic        valid;
    logic        reset_cnt;
    logic        raise_irq;
    logic [15:0] value;
  } mec_entry_t;

  // sampled external event sensors
  typedef struct packed {
    logic counter_clock_pin;
    logic counter_reset_pin;
    logic cap0;
    logic cap1;
  } mec_pins_t;

endpackage

/* File: verilog/mec_match_store.sv */
`timescale 1ns/100ps
module mec_match_store
  import mec_pkg::*;
#(
  parameter int DEPTH = MEC_ENTRIES
) (
  input  wire logic                     clk_in,
  input  wire logic                     arst_n_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
  input  wire mec_entry_t               wr_data_in,
  input  wire logic                     clr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] clr_idx_in,
  output mec_entry_t                    entry_out [DEPTH]
);

  if (DEPTH < MEC_ENTRIES) begin : g_bad_depth
    $error("mec_match_store: depth below two");
  end

  mec_entry_t mem_r   [DEPTH];
  mec_entry_t mem_nxt [DEPTH];

  // ------------------------------------------------------------------
  // entry update; a write beats a same-cycle clear
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
      if (clr_en_in && clr_idx_in == i[$clog2(DEPTH)-1:0]) begin
        mem_nxt[i].valid = 1'b0;
      end
      if (wr_en_in && wr_idx_in == i[$clog2(DEPTH)-1:0]) begin
        mem_nxt[i] = wr_data_in;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          mem_r[g] <= '0;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
      assign entry_out[g] = mem_r[g];
    end
  endgenerate

endmodule

/* File: verilog/mec_counter.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Overview of operation
// - match entry can reset counter at value
// - zero-count interrupt; software reloads store, two entries
// - reset pin rising edge clears counter
// - capture zero resets, interrupts, records time
// - capture zero has its own interrupt
// - capture one clocks counter, edges time-stamped
// - match at count triggers programmed action
// ------------------------------------------------------------------
module mec_counter
  import mec_pkg::*;
#(
  parameter int CNT_W = MEC_CNT_W,
  parameter int DEPTH = MEC_ENTRIES
) (
  input  wire logic                     clk_in,
  input  wire logic                     arst_n_in,
  input  wire mec_pins_t                pins_in,
  input  wire logic [CNT_W-1:0]         time_base_in,
  input  wire mec_clk_sel_t             clk_sel_in,
  input  wire mec_rst_sel_t             rst_sel_in,
  input  wire logic                     ms_wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] ms_wr_idx_in,
  input  wire mec_entry_t               ms_wr_data_in,
  input  wire logic                     zero_irq_en_in,
  output logic [CNT_W-1:0]              count_out,
  output logic                          cap0_irq_out,
  output logic [CNT_W-1:0]              cap0_time_out,
  output logic                          cap1_stamp_out,
  output logic [CNT_W-1:0]              cap1_time_out,
  output logic                          zero_irq_out,
  output logic                          match_action_out,
  output logic [$clog2(DEPTH)-1:0]      match_idx_out
);

  // the match store only compares full 16-bit words
  if (CNT_W != MEC_CNT_W) begin : g_bad_width
    $error("mec_counter: width must be 16");
  end
  // a reset entry plus a reload entry need two slots
  if (DEPTH < MEC_ENTRIES) begin : g_bad_depth
    $error("mec_counter: depth below two");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  mec_pins_t                pins_q_r,   pins_q_nxt;
  logic [CNT_W-1:0]         count_r,    count_nxt;
  logic                     cap0_irq_r, cap0_irq_nxt;
  logic [CNT_W-1:0]         cap0_t_r,   cap0_t_nxt;
  logic                     cap1_st_r,  cap1_st_nxt;
  logic [CNT_W-1:0]         cap1_t_r,   cap1_t_nxt;
  logic                     zero_r,     zero_nxt;
  logic                     act_r,      act_nxt;
  logic [$clog2(DEPTH)-1:0] idx_r,      idx_nxt;
  logic                     clr_en;
  logic [$clog2(DEPTH)-1:0] clr_idx;
  mec_entry_t               ent [DEPTH];

  // entries are one-shot, software reloads them (e.g. at zero)
  mec_match_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .wr_en_in   (ms_wr_en_in),
    .wr_idx_in  (ms_wr_idx_in),
    .wr_data_in (ms_wr_data_in),
    .clr_en_in  (clr_en),
    .clr_idx_in (clr_idx),
    .entry_out  (ent)
  );

  // ------------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------------
  // history clears low, the idle level of every sensor line
  logic clk_edge;
  logic pin_rst_edge;
  logic cap0_edge;
  logic cap1_edge;

  always_comb begin
    pins_q_nxt = pins_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_q_r <= '0;
    end else begin
      pins_q_r <= pins_q_nxt;
    end
  end

  always_comb begin
    pin_rst_edge = pins_in.counter_reset_pin & ~pins_q_r.counter_reset_pin;
    cap0_edge    = pins_in.cap0 & ~pins_q_r.cap0;
    cap1_edge    = pins_in.cap1 & ~pins_q_r.cap1;
    case (clk_sel_in)
      MEC_CLK_PIN: begin
        clk_edge = pins_in.counter_clock_pin & ~pins_q_r.counter_clock_pin;
      end
      MEC_CLK_CAP1: begin
        clk_edge = cap1_edge;
      end
      default: begin
        clk_edge = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // match search over the store
  // ------------------------------------------------------------------
  localparam int IDX_W = $clog2(DEPTH);

  logic [DEPTH-1:0] ent_hit;
  logic             hit;
  logic             hit_rst;
  logic             hit_irq;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      assign ent_hit[g] = ent[g].valid && ent[g].value == count_r;
    end
  endgenerate

  // lowest index wins; the hit entry is spent at the same edge
  always_comb begin
    hit     = 1'b0;
    hit_rst = 1'b0;
    hit_irq = 1'b0;
    clr_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (ent_hit[i]) begin
        hit     = 1'b1;
        hit_rst = ent[i].reset_cnt;
        hit_irq = ent[i].raise_irq;
        clr_idx = i[IDX_W-1:0];
      end
    end
    clr_en = hit;
  end

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  // a reset outranks a counting edge in the same cycle
  always_comb begin
    count_nxt = count_r;
    if (clk_edge) begin
      count_nxt = count_r + MEC_CNT_STEP;
    end
    case (rst_sel_in)
      MEC_RST_PIN: begin
        if (pin_rst_edge) begin
          count_nxt = MEC_CNT_RST;
        end
      end
      MEC_RST_CAP0: begin
        if (cap0_edge) begin
          count_nxt = MEC_CNT_RST;
        end
      end
      MEC_RST_MATCH: begin
        if (hit && hit_rst) begin
          count_nxt = MEC_CNT_RST;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_r <= MEC_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ------------------------------------------------------------------
  // captures
  // ------------------------------------------------------------------
  // capture zero keeps its own interrupt whatever the reset choice
  always_comb begin
    cap0_irq_nxt = cap0_edge;
    cap0_t_nxt   = cap0_t_r;
    cap1_st_nxt  = cap1_edge;
    cap1_t_nxt   = cap1_t_r;
    if (cap0_edge) begin
      cap0_t_nxt = time_base_in;
    end
    if (cap1_edge) begin
      cap1_t_nxt = time_base_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cap0_irq_r <= 1'b0;
      cap0_t_r   <= '0;
      cap1_st_r  <= 1'b0;
      cap1_t_r   <= '0;
    end else begin
      cap0_irq_r <= cap0_irq_nxt;
      cap0_t_r   <= cap0_t_nxt;
      cap1_st_r  <= cap1_st_nxt;
      cap1_t_r   <= cap1_t_nxt;
    end
  end

  // ------------------------------------------------------------------
  // events
  // ------------------------------------------------------------------
  // zero interrupt on entry to zero, by wrap or by reset
  always_comb begin
    zero_nxt = 1'b0;
    if (zero_irq_en_in && count_nxt == MEC_CNT_RST &&
        count_r != MEC_CNT_RST) begin
      zero_nxt = 1'b1;
    end
    act_nxt = hit && (hit_irq || !hit_rst);
    idx_nxt = idx_r;
    if (hit) begin
      idx_nxt = clr_idx;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      zero_r <= 1'b0;
      act_r  <= 1'b0;
      idx_r  <= '0;
    end else begin
      zero_r <= zero_nxt;
      act_r  <= act_nxt;
      idx_r  <= idx_nxt;
    end
  end

  assign count_out        = count_r;
  assign cap0_irq_out     = cap0_irq_r;
  assign cap0_time_out    = cap0_t_r;
  assign cap1_stamp_out   = cap1_st_r;
  assign cap1_time_out    = cap1_t_r;
  assign zero_irq_out     = zero_r;
  assign match_action_out = act_r;
  assign match_idx_out    = idx_r;

endmodule

/* File: verif/mec_counter_props.sv */
`timescale 1ns/100ps
module mec_counter_props
  import mec_pkg::*;
#(parameter int CNT_W = MEC_CNT_W) (
  input wire logic             clk_in,
  input wire logic             arst_n_in,
  input wire mec_pins_t        pins_in,
  input wire logic [CNT_W-1:0] time_base_in,
  input wire mec_clk_sel_t     clk_sel_in,
  input wire mec_rst_sel_t     rst_sel_in,
  input wire logic [CNT_W-1:0] count_out,
  input wire logic             cap0_irq_out,
  input wire logic [CNT_W-1:0] cap0_time_out,
  input wire logic             cap1_stamp_out,
  input wire logic [CNT_W-1:0] cap1_time_out
);
  mec_pins_t prev_r;
  mec_pins_t rise;
  logic      step;
  // history clears with reset, as in the design
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) prev_r <= '0;
    else prev_r <= pins_in;
  end
  assign rise = pins_in & ~prev_r;
  assign step = clk_sel_in ? rise.cap1 : rise.counter_clock_pin;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_pin_clear: assert property (rise.counter_reset_pin &&
    rst_sel_in == MEC_RST_PIN |=> count_out == 0) else $error("pin clr");
  chk_cap0_clear: assert property (rise.cap0 &&
    rst_sel_in == MEC_RST_CAP0 |=> count_out == 0) else $error("cap0 clr");
  chk_cap0_event: assert property (rise.cap0 |=>
    cap0_irq_out && cap0_time_out == $past(time_base_in)) else $error("c0");
  chk_cap0_cause: assert property (
    cap0_irq_out |-> $past(rise.cap0)) else $error("cap0 irq cause");
  chk_cap1_stamp: assert property (rise.cap1 |=>
    cap1_stamp_out && cap1_time_out == $past(time_base_in)) else $error("c1");
  chk_cap1_cause: assert property (
    cap1_stamp_out |-> $past(rise.cap1)) else $error("cap1 cause");
  chk_count_step: assert property (step && rst_sel_in == 0 |=>
    count_out == $past(count_out) + MEC_CNT_STEP) else $error("step");
  chk_count_hold: assert property (!step && rst_sel_in == 0 |=>
    $stable(count_out)) else $error("hold");
endmodule
bind mec_counter mec_counter_props #(.CNT_W(CNT_W)) u_props (.clk_in,
  .arst_n_in, .pins_in, .time_base_in, .clk_sel_in, .rst_sel_in,
  .count_out, .cap0_irq_out, .cap0_time_out, .cap1_stamp_out,
  .cap1_time_out);

/* File: verif/mec_sensor_model.sv */
`timescale 1ns/100ps
module mec_sensor_model
  import mec_pkg::*;
(
  input  wire logic clk_in,
  output mec_pins_t pins_out
);
  initial pins_out = '0;
  // one high sample then low, so two edges never merge
  task automatic pulse(input int idx);
    @(posedge clk_in);
    pins_out[idx] <= 1'b1;
    @(posedge clk_in);
    pins_out[idx] <= 1'b0;
  endtask
endmodule

/* File: verif/test_modulo_event_counter.sv */
`timescale 1ns/100ps
module test_modulo_event_counter
  import mec_pkg::*;
;
  logic         clk_in;
  logic         arst_n_in;
  mec_pins_t    pins;
  logic [15:0]  tbase;
  mec_clk_sel_t csel;
  mec_rst_sel_t rsel;
  logic         wr_en;
  logic         wr_idx;
  mec_entry_t   wr_data;
  logic         zen;
  logic [15:0]  cnt;
  logic         c0_irq;
  logic [15:0]  c0_time;
  logic         c1_stamp;
  logic [15:0]  c1_time;
  logic         z_irq;
  logic         m_act;
  logic         m_idx;
  int           n_errors;
  int           comparisons;
  mec_counter u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .pins_in(pins), .time_base_in(tbase), .clk_sel_in(csel),
    .rst_sel_in(rsel), .ms_wr_en_in(wr_en), .ms_wr_idx_in(wr_idx),
    .ms_wr_data_in(wr_data), .zero_irq_en_in(zen), .count_out(cnt),
    .cap0_irq_out(c0_irq), .cap0_time_out(c0_time),
    .cap1_stamp_out(c1_stamp), .cap1_time_out(c1_time),
    .zero_irq_out(z_irq), .match_action_out(m_act), .match_idx_out(m_idx));
  mec_sensor_model u_sens (.clk_in(clk_in), .pins_out(pins));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) tbase <= tbase + 16'h0001;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons=%0d errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cfg(input mec_clk_sel_t c, input mec_rst_sel_t r);
    @(posedge clk_in);
    csel <= c;
    rsel <= r;
  endtask
  task wr(input logic i, input logic [15:0] v, input logic rc,
          input logic ri);
    @(posedge clk_in);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_data <= '{1'b1, rc, ri, v};
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask
  // bounded look for both one-cycle pulses
  task wait_flag(input logic exp_zero, input logic exp_act);
    logic hz;
    logic ha;
    hz = 1'b0;
    ha = 1'b0;
    repeat (4) begin
      #1;
      if (z_irq === 1'b1) hz = 1'b1;
      if (m_act === 1'b1) ha = 1'b1;
      @(posedge clk_in);
    end
    chk(hz, exp_zero);
    chk(ha, exp_act);
  endtask
  task t_pin;
    cfg(MEC_CLK_PIN, MEC_RST_NONE);
    repeat (3) u_sens.pulse(3);
    u_sens.pulse(0);
    #1 chk(cnt, 16'h0003);
    cfg(MEC_CLK_PIN, MEC_RST_PIN);
    u_sens.pulse(2);
    #1 chk(cnt, 16'h0000);
    wait_flag(1'b1, 1'b0);
    $display("pin test done");
  endtask
  task t_cap;
    cfg(MEC_CLK_CAP1, MEC_RST_CAP0);
    u_sens.pulse(0);
    #1 chk(c1_stamp, 1'b1);
    chk(c1_time, tbase - 16'h0001);
    u_sens.pulse(3);
    #1 chk(cnt, 16'h0001);
    u_sens.pulse(1);
    #1 chk(c0_irq, 1'b1);
    chk(c0_time, tbase - 16'h0001);
    chk(cnt, 16'h0000);
    $display("capture test done");
  endtask
  task t_match;
    cfg(MEC_CLK_PIN, MEC_RST_MATCH);
    wr(1'b1, 16'h0002, 1'b0, 1'b1);
    wr(1'b0, 16'h0004, 1'b1, 1'b1);
    repeat (2) u_sens.pulse(3);
    wait_flag(1'b0, 1'b1);
    chk(m_idx, 1'b1);
    chk(cnt, 16'h0002);
    repeat (2) u_sens.pulse(3);
    wait_flag(1'b1, 1'b1);
    chk(m_idx, 1'b0);
    chk(cnt, 16'h0000);
    $display("match test done");
  endtask
  // silent reset entry with the zero interrupt masked
  task t_quiet;
    @(posedge clk_in);
    zen <= 1'b0;
    wr(1'b0, 16'h0001, 1'b1, 1'b0);
    u_sens.pulse(3);
    wait_flag(1'b0, 1'b0);
    chk(cnt, 16'h0000);
    $display("quiet match test done");
  endtask
  // reset in mid-run clears count and capture zero time
  task t_reset;
    cfg(MEC_CLK_PIN, MEC_RST_NONE);
    u_sens.pulse(3);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1 chk(cnt, MEC_CNT_RST);
    chk(c0_time, 16'h0000);
    $display("reset test done");
  endtask
  initial begin
    arst_n_in = 1'b0;
    wr_en = 1'b0;
    wr_idx = 1'b0;
    wr_data = '0;
    tbase = 16'h0000;
    csel = MEC_CLK_PIN;
    rsel = MEC_RST_NONE;
    n_errors = 0;
    comparisons = 0;
    zen = 1'b1;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_pin;
    t_cap;
    t_match;
    t_quiet;
    t_reset;
    stop_test;
  end
  initial begin
    #20000;
    n_errors++;
    stop_test;
  end
endmodule
